// File: core/capture_compare_unit.sv
// Two-channel capture/compare/PWM unit with its counter and registers
//
// Functional notes
// - Active pin edge copies counter into channel value pair.
// - Edge level field picks rising, falling or both edges for capture.
// - Capture event can raise a channel interrupt request.
// - Counter equal to channel value sets, clears or toggles pin.
// - Compare match can raise a channel interrupt request.
// - Unbuffered writes change compare value immediately; mistimed writes may miss.
// - Link select on channel 0 pairs both channels onto channel 0 pin.
// - Buffered: channel 1 write takes control at next overflow.
// - Buffered: each overflow hands control to most recently written pair.
// - Linked: channel 0 control governs, channel 1 pin released.
// - Toggle on overflow toggles pin when counter hits modulo.
// - PWM period is modulo plus one counter clocks.
// - Pulse width runs from overflow to compare match.
// - Mode 0:1 unbuffered compare, 1:0 buffered compare.
// - Compare action 1:0 clears pin, 1:1 sets pin.
// - Without overflow toggle a clear action holds the pin low: zero duty.
// - Max duty plus overflow toggle gives constant full duty.
// - Capture or compare sets the channel event flag.
// - At modulo the overflow flag sets and counter restarts at zero.
`timescale 1ns/100ps
module capture_compare_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [capcomp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [capcomp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [capcomp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] chan_pin_i,
  output logic [1:0] chan_pin_o,
  output logic [1:0] chan_pin_oe_n,
  output logic [1:0] chan_irq,
  output logic overflow_irq
);
  import capcomp_pkg::*;

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  function automatic logic [3:0] chan_addr(input logic ch,
                                           input logic [1:0] fld);
    chan_addr = OFF_CH0_CTRL + (ch ? CH_STRIDE : 4'h0) + {2'h0, fld};
  endfunction

  pin_edge_if pe();
  assign pe.pin_raw = chan_pin_i;
  pin_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .pe(pe.det)
  );

  logic [7:0] cc_q;
  logic ovf_q;
  logic ovf_arm_q;
  logic [PRE_W-1:0] pre_q;
  count_t cnt_q;
  count_t mod_q;
  logic mod_hold_q;
  logic [7:0] cnt_lat_q;
  logic lat_valid_q;
  logic [7:0] rdata_q;
  logic act_sel_q;
  logic last_wr_q;

  logic [7:0] ctrl_q [NCHAN];
  count_t val_q [NCHAN];
  logic [NCHAN-1:0] flag_q;
  logic [NCHAN-1:0] flag_arm_q;
  logic [NCHAN-1:0] pin_q;
  logic [NCHAN-1:0] cmp_mode;
  logic [NCHAN-1:0] wr_ctrl;
  logic [NCHAN-1:0] wr_val;
  logic [7:0] ch_rd [NCHAN][3];

  wire wr_cc = reg_wr && reg_addr == OFF_CNT_CTRL;
  wire rd_cc = reg_rd && reg_addr == OFF_CNT_CTRL;
  wire wr_mod_hi = reg_wr && reg_addr == OFF_MOD_HI;
  wire wr_mod_lo = reg_wr && reg_addr == OFF_MOD_LO;
  wire rd_cnt_hi = reg_rd && reg_addr == OFF_CNT_HI;
  wire rd_cnt_lo = reg_rd && reg_addr == OFF_CNT_LO;
  wire halt = cc_q[CC_HALT_BIT];
  wire [2:0] ps = cc_q[CC_PS_LSB +: 3];
  wire cnt_reset = wr_cc && reg_wdata[CC_RST_BIT];
  wire linked = ctrl_q[0][CH_MSB_BIT];

  // ------------------------------------------------------------------
  // Prescaler and counter
  // ------------------------------------------------------------------
  wire [PRE_W:0] pre_full = (7'h01 << ps) - 7'h01;
  wire [PRE_W-1:0] pre_mask = pre_full[PRE_W-1:0];
  wire tick = !halt && ps != PS_NONE && (pre_q & pre_mask) == 6'h00;
  wire at_mod = cnt_q == mod_q;
  // Compares look at the value being entered, so that a channel value of N
  // gives a pulse of N ticks after the overflow toggle, not N plus one
  wire [15:0] cnt_nxt = at_mod ? 16'h0000 : cnt_q + 16'h0001;
  wire ovf_tick = tick && at_mod;
  // A half-written modulo must not raise a spurious overflow flag
  wire ovf_ev = ovf_tick && !mod_hold_q;
  wire ovf_clr = wr_cc && !reg_wdata[CC_OVF_BIT] && ovf_arm_q;

  always_ff @(posedge clk_sys) begin
    if (rst || cnt_reset) begin
      pre_q <= 6'h00;
    end else if (!halt) begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || cnt_reset) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cc_q <= CC_RESET;
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else begin
      if (wr_cc) begin
        cc_q <= {2'b00, reg_wdata[CC_HALT_BIT], 1'b0,
                 reg_wdata[3:0]} | {1'b0, reg_wdata[CC_OIE_BIT], 6'h00};
      end
      // Set wins over a clear in the same cycle
      ovf_q <= ovf_ev | (ovf_q & ~ovf_clr);
      if (ovf_ev || ovf_clr) begin
        ovf_arm_q <= 1'b0;
      end else if (rd_cc && ovf_q) begin
        ovf_arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mod_q <= MOD_RESET;
      mod_hold_q <= 1'b0;
    end else if (wr_mod_hi) begin
      mod_q[15:8] <= reg_wdata;
      mod_hold_q <= 1'b1;
    end else if (wr_mod_lo) begin
      mod_q[7:0] <= reg_wdata;
      mod_hold_q <= 1'b0;
    end
  end

  // Reading the high byte freezes the low byte for a coherent pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_lat_q <= 8'h00;
      lat_valid_q <= 1'b0;
    end else if (rd_cnt_hi && !lat_valid_q) begin
      cnt_lat_q <= cnt_q[7:0];
      lat_valid_q <= 1'b1;
    end else if (rd_cnt_lo) begin
      lat_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Buffered pair selection
  // ------------------------------------------------------------------
  wire link_rise = wr_ctrl[0] && reg_wdata[CH_MSB_BIT] && !linked;

  always_ff @(posedge clk_sys) begin
    if (rst || link_rise) begin
      act_sel_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else begin
      if (wr_val[1]) begin
        last_wr_q <= 1'b1;
      end else if (wr_val[0]) begin
        last_wr_q <= 1'b0;
      end
      if (ovf_tick && linked) begin
        act_sel_q <= last_wr_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    wire is_ch1 = c == 1;
    wire [1:0] mode = {ctrl_q[c][CH_MSB_BIT], ctrl_q[c][CH_MSA_BIT]};
    wire [1:0] els = {ctrl_q[c][CH_ELSB_BIT], ctrl_q[c][CH_ELSA_BIT]};
    wire tov = ctrl_q[c][CH_TOV_BIT];
    wire max_duty = ctrl_q[c][CH_MAX_BIT];
    wire released = is_ch1 && linked;
    wire cap_mode = mode == MODE_CAPTURE && !released;
    wire edge_hit = (els[0] && pe.rise[c]) || (els[1] && pe.fall[c]);
    // Captures are inhibited while the counter is halted
    wire cap_ev = cap_mode && edge_hit && !halt;
    wire use_buf = !is_ch1 && linked;
    wire [15:0] cmp_val = use_buf ? val_q[act_sel_q] : val_q[c];
    wire cmp_ev = cmp_mode[c] && tick && cnt_nxt == cmp_val;
    wire ev = cap_ev | cmp_ev;
    wire flag_clr = wr_ctrl[c] && !reg_wdata[CH_FLAG_BIT] && flag_arm_q[c];
    wire rd_ctrl = reg_rd && reg_addr == chan_addr(c[0], FLD_CTRL);
    wire wr_hi = reg_wr && reg_addr == chan_addr(c[0], FLD_HI);
    wire wr_lo = reg_wr && reg_addr == chan_addr(c[0], FLD_LO);

    assign cmp_mode[c] = mode != MODE_CAPTURE && !released;
    assign wr_ctrl[c] = reg_wr && reg_addr == chan_addr(c[0], FLD_CTRL);
    assign wr_val[c] = wr_hi || wr_lo;
    assign ch_rd[c][0] = {flag_q[c], ctrl_q[c][6:0]};
    assign ch_rd[c][1] = val_q[c][15:8];
    assign ch_rd[c][2] = val_q[c][7:0];
    assign chan_irq[c] = flag_q[c] & ctrl_q[c][CH_IE_BIT];
    assign chan_pin_o[c] = pin_q[c];
    assign chan_pin_oe_n[c] = !(cmp_mode[c] && els != ELS_OFF);

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        ctrl_q[c] <= CH_CTRL_RESET;
        flag_q[c] <= 1'b0;
        flag_arm_q[c] <= 1'b0;
      end else begin
        if (wr_ctrl[c]) begin
          // Channel 1 has no link select bit
          ctrl_q[c] <= {1'b0, reg_wdata[6],
                        reg_wdata[CH_MSB_BIT] & !is_ch1, reg_wdata[4:0]};
        end
        flag_q[c] <= ev | (flag_q[c] & ~flag_clr);
        if (ev || flag_clr) begin
          flag_arm_q[c] <= 1'b0;
        end else if (rd_ctrl && flag_q[c]) begin
          flag_arm_q[c] <= 1'b1;
        end
      end
    end

    // Capture beats a software write landing in the same cycle
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        val_q[c] <= CH_VAL_RESET;
      end else if (cap_ev) begin
        val_q[c] <= cnt_q;
      end else if (wr_hi) begin
        val_q[c][15:8] <= reg_wdata;
      end else if (wr_lo) begin
        val_q[c][7:0] <= reg_wdata;
      end
    end

    // Compare forces win over the overflow toggle when both coincide
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pin_q[c] <= 1'b0;
      end else if (!cmp_mode[c]) begin
        pin_q[c] <= 1'b0;
      end else if (max_duty && tov) begin
        pin_q[c] <= ~els[0];
      end else if (cmp_ev) begin
        case (els)
          ELS_RISE_TOGGLE: pin_q[c] <= ~pin_q[c];
          ELS_FALL_CLEAR: pin_q[c] <= 1'b0;
          ELS_BOTH_SET: pin_q[c] <= 1'b1;
          default: pin_q[c] <= pin_q[c];
        endcase
      end else if (ovf_tick && tov) begin
        pin_q[c] <= ~pin_q[c];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  wire [7:0] cc_rd = {ovf_q, cc_q[6:5], 1'b0, cc_q[3:0]};
  wire [7:0] cnt_lo_rd = lat_valid_q ? cnt_lat_q : cnt_q[7:0];
  wire [3:0] ch_off = reg_addr - OFF_CH0_CTRL;
  wire ch_sel = ch_off >= CH_STRIDE;
  wire [3:0] fld_off = ch_sel ? ch_off - CH_STRIDE : ch_off;
  wire ch_hit = reg_addr >= OFF_CH0_CTRL &&
                ch_off < (CH_STRIDE + CH_STRIDE);
  wire [7:0] rd_mux =
    reg_addr == OFF_CNT_CTRL ? cc_rd :
    reg_addr == OFF_CNT_HI ? cnt_q[15:8] :
    reg_addr == OFF_CNT_LO ? cnt_lo_rd :
    reg_addr == OFF_MOD_HI ? mod_q[15:8] :
    reg_addr == OFF_MOD_LO ? mod_q[7:0] :
    ch_hit ? ch_rd[ch_sel][fld_off[1:0]] : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign overflow_irq = ovf_q & cc_q[CC_OIE_BIT];
endmodule

// File: core/capcomp_pkg.sv
// Constants shared by the capture/compare unit, its checker and its bench
package capcomp_pkg;

  // ------------------------------------------------------------------
  // Register bus shape and unit sizes
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NCHAN = 2;
  localparam int PRE_W = 6;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] OFF_CNT_CTRL = 4'h0;
  localparam logic [3:0] OFF_CNT_HI = 4'h1;
  localparam logic [3:0] OFF_CNT_LO = 4'h2;
  localparam logic [3:0] OFF_MOD_HI = 4'h3;
  localparam logic [3:0] OFF_MOD_LO = 4'h4;
  localparam logic [3:0] OFF_CH0_CTRL = 4'h5;
  localparam logic [3:0] CH_STRIDE = 4'h3;
  localparam logic [1:0] FLD_CTRL = 2'h0;
  localparam logic [1:0] FLD_HI = 2'h1;
  localparam logic [1:0] FLD_LO = 2'h2;

  // ------------------------------------------------------------------
  // Counter control fields
  // ------------------------------------------------------------------
  localparam int CC_OVF_BIT = 7;
  localparam int CC_OIE_BIT = 6;
  localparam int CC_HALT_BIT = 5;
  localparam int CC_RST_BIT = 4;
  localparam int CC_PS_LSB = 0;
  localparam logic [2:0] PS_NONE = 3'h7;

  // ------------------------------------------------------------------
  // Channel control fields
  // ------------------------------------------------------------------
  localparam int CH_FLAG_BIT = 7;
  localparam int CH_IE_BIT = 6;
  localparam int CH_MSB_BIT = 5;
  localparam int CH_MSA_BIT = 4;
  localparam int CH_ELSB_BIT = 3;
  localparam int CH_ELSA_BIT = 2;
  localparam int CH_TOV_BIT = 1;
  localparam int CH_MAX_BIT = 0;

  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_UNBUF = 2'h1;
  localparam logic [1:0] MODE_BUF = 2'h2;

  // Edge/level field: capture edge or compare action
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_BOTH_SET = 2'h3;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CC_RESET = 8'h20;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [7:0] CH_CTRL_RESET = 8'h00;
  localparam logic [15:0] CH_VAL_RESET = 16'h0000;

  typedef logic [CNT_W-1:0] count_t;

endpackage

// File: core/pin_edge_if.sv
// Synchronised channel pin levels and edges
`timescale 1ns/100ps
interface pin_edge_if;
  logic [1:0] pin_raw;
  logic [1:0] level;
  logic [1:0] rise;
  logic [1:0] fall;
  modport det(input pin_raw, output level, output rise, output fall);
  modport user(output pin_raw, input level, input rise, input fall);
endinterface

// File: core/pin_edge_detect.sv
// Two-stage synchroniser and edge detector for the channel pins
`timescale 1ns/100ps
module pin_edge_detect (
  input wire logic clk_sys,
  input wire logic rst,
  pin_edge_if.det pe
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      meta_q <= pe.pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Only the second stage feeds the edge logic
  assign pe.level = sync_q;
  assign pe.rise = sync_q & ~prev_q;
  assign pe.fall = ~sync_q & prev_q;
endmodule

// File: testbench/pin_partner.sv
// Outside circuit on the two channel pins
`timescale 1ns/100ps
module pin_partner (
  input wire logic [1:0] ext_level,
  input wire logic [1:0] chan_pin_o,
  input wire logic [1:0] chan_pin_oe_n,
  output logic [1:0] chan_pin_i
);
  // The device wins where it drives; elsewhere the outside source holds
  // the line, so a released pin never floats
  assign chan_pin_i = (~chan_pin_oe_n & chan_pin_o) |
                      (chan_pin_oe_n & ext_level);
endmodule

// File: testbench/capture_compare_unit_asserts.sv
// Port checker for the capture/compare unit
`timescale 1ns/100ps
module capture_compare_unit_asserts
  import capcomp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [capcomp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [capcomp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [capcomp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] chan_pin_i,
  input wire logic [1:0] chan_pin_o,
  input wire logic [1:0] chan_pin_oe_n,
  input wire logic [1:0] chan_irq,
  input wire logic overflow_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // Shadow of the link select
  // ----
  wire ch0_wr = reg_wr && reg_addr == OFF_CH0_CTRL;
  wire ch1_wr = reg_wr && reg_addr == 4'h8;
  logic link_q;
  always_ff @(posedge clk_sys) begin
    if (rst)
      link_q <= 1'b0;
    else if (ch0_wr)
      link_q <= reg_wdata[CH_MSB_BIT];
  end
  sequence s_max_set;
    ch0_wr && reg_wdata == 8'h1B;
  endsequence
  sequence s_ch0_quiet;
    !ch0_wr [*4];
  endsequence
  property p_rst_idle;
    $fell(rst) |-> chan_pin_oe_n == 2'h3 && chan_pin_o == 2'h0 &&
      chan_irq == 2'h0 && !overflow_irq;
  endproperty
  property p_link_pins;
    ch0_wr && reg_wdata[5:4] == MODE_BUF && reg_wdata[3:2] != ELS_OFF
      |=> !chan_pin_oe_n[0] && chan_pin_oe_n[1];
  endproperty
  property p_ch1_release;
    link_q |-> chan_pin_oe_n[1];
  endproperty
  property p_unbuf_drive;
    ch1_wr && reg_wdata[5:4] == MODE_UNBUF && reg_wdata[3:2] != ELS_OFF &&
      !link_q |=> !chan_pin_oe_n[1];
  endproperty
  property p_irq_off;
    ch0_wr && !reg_wdata[CH_IE_BIT] |=> !chan_irq[0];
  endproperty
  property p_ovf_off;
    reg_wr && reg_addr == OFF_CNT_CTRL && !reg_wdata[CC_OIE_BIT]
      |=> !overflow_irq;
  endproperty
  property p_max_full;
    s_max_set ##1 s_ch0_quiet |-> chan_pin_o[0];
  endproperty
  property p_rd_stand;
    reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("pins or requests active after reset");
  a_link_pins: assert property (p_link_pins)
    else $error("linked pair not on channel 0 pin");
  a_ch1_release: assert property (p_ch1_release)
    else $error("channel 1 pin driven while linked");
  a_unbuf_drive: assert property (p_unbuf_drive)
    else $error("unbuffered compare pin not driven");
  a_irq_off: assert property (p_irq_off)
    else $error("channel request with enable clear");
  a_ovf_off: assert property (p_ovf_off)
    else $error("overflow request with enable clear");
  a_max_full: assert property (p_max_full)
    else $error("full duty output not high");
  a_rd_stand: assert property (p_rd_stand)
    else $error("read data held past one cycle");
endmodule
bind capture_compare_unit capture_compare_unit_asserts u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o),
  .chan_pin_oe_n(chan_pin_oe_n), .chan_irq(chan_irq),
  .overflow_irq(overflow_irq));

// File: testbench/tb.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/100ps
module tb;
  import capcomp_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, overflow_irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [1:0] chan_pin_i, chan_pin_o, chan_pin_oe_n, chan_irq, ext_level;
  int fails, checks, cyc, t0, t1, t2;
  capture_compare_unit dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_pin_i(chan_pin_i),
    .chan_pin_o(chan_pin_o), .chan_pin_oe_n(chan_pin_oe_n),
    .chan_irq(chan_irq), .overflow_irq(overflow_irq));
  pin_partner u_pins (.ext_level(ext_level), .chan_pin_o(chan_pin_o),
    .chan_pin_oe_n(chan_pin_oe_n), .chan_pin_i(chan_pin_i));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ----
  // Bus and pin tasks
  // ----
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  // Waits for a pin 0 level; a required level that never comes ends the run
  task automatic pin_at(input logic v, input bit must, output int t);
    t = -1;
    for (int i = 0; i < 60 && t < 0; i++) begin
      @(negedge clk_sys);
      if (chan_pin_o[0] === v)
        t = cyc;
    end
    if (must && t < 0) begin
      fails++;
      $display("MISMATCH t=%0t pin level never reached", $time);
      final_report();
    end
  endtask
  task automatic lead(input logic a, output int t);
    pin_at(!a, 1, t);
    pin_at(a, 1, t);
  endtask
  // Halt and clear, program period and width, then run
  task automatic setup(input logic [15:0] v, input logic [7:0] c);
    wr(OFF_CNT_CTRL, 8'h30);
    wr16(OFF_MOD_HI, 16'h000F);
    wr16(4'h6, v);
    wr(OFF_CH0_CTRL, c);
    wr(OFF_CNT_CTRL, 8'h00);
  endtask
  task automatic cap(input logic lv, input logic exp);
    logic [15:0] c, v;
    rd(4'h9, c[15:8]);
    rd(4'hA, c[7:0]);
    @(posedge clk_sys);
    ext_level[1] <= lv;
    repeat (8) @(posedge clk_sys);
    rd(4'h9, v[15:8]);
    rd(4'hA, v[7:0]);
    chk(v !== c, exp);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    cyc = 0;
    fails = 0;
    checks = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    ext_level = 2'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_CNT_CTRL, d);
    chk(d, CC_RESET);
    rd(OFF_MOD_LO, d);
    chk(d, 8'hFF);
    wr(4'h8, 8'h18);
    for (int e = 3; e >= 2; e--) begin
      setup(16'h0008, 8'h12 | 8'(e << 2));
      lead(!e[0], t0);
      pin_at(e[0], 1, t1);
      pin_at(!e[0], 1, t2);
      chk(16'(t1 - t0), 16'd8);
      chk(16'(t2 - t0), 16'd16);
    end
    rd(OFF_CH0_CTRL, d);
    chk(d[CH_FLAG_BIT], 1'b1);
    lead(1'b1, t0);
    wr16(4'h6, 16'h0002);
    pin_at(1'b0, 1, t1);
    chk(16'(t1 - t0), 16'd16);
    // A larger width goes in after this period's compare match, well before the next overflow, so none is lost
    wr16(4'h6, 16'h0006);
    lead(1'b1, t0);
    pin_at(1'b0, 1, t1);
    chk(16'(t1 - t0), 16'd6);
    rd(OFF_CNT_CTRL, d);
    chk(d, 8'h80);
    wr(OFF_CNT_CTRL, 8'h40);
    rd(OFF_CNT_CTRL, d);
    chk(d, 8'h40);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(overflow_irq, 1'b1);
    setup(16'h0008, 8'h2A);
    chk(chan_pin_oe_n, 2'h2);
    lead(1'b1, t0);
    wr16(4'h9, 16'h0003);
    pin_at(1'b0, 1, t1);
    chk(16'(t1 - t0), 16'd8);
    lead(1'b1, t0);
    pin_at(1'b0, 1, t1);
    chk(16'(t1 - t0), 16'd3);
    wr16(4'h6, 16'h0005);
    lead(1'b1, t0);
    pin_at(1'b0, 1, t1);
    chk(16'(t1 - t0), 16'd5);
    setup(16'h0004, 8'h18);
    pin_at(1'b0, 1, t0);
    pin_at(1'b1, 0, t1);
    chk(t1 < 0, 1'b1);
    wr(OFF_CH0_CTRL, 8'h1B);
    pin_at(1'b1, 1, t0);
    pin_at(1'b0, 0, t1);
    chk(t1 < 0, 1'b1);
    wr(OFF_CH0_CTRL, 8'h5A);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(chan_irq[0], 1'b1);
    wr16(OFF_MOD_HI, 16'hFFFF);
    for (int e = 1; e < 4; e++) begin
      wr(4'h8, 8'h40 | 8'(e << 2));
      cap(1'b1, e[0]);
      cap(1'b0, e[1]);
    end
    chk(chan_irq[1], 1'b1);
    final_report();
  end
endmodule
